// ---- rtl/adc_ctrl.sv ----
// converter control: sampling phase, registers, channel and code format
// What this block does
// - after reset results come out in two's complement
// - coding bit written as one gives straight binary results
// - sequenced channels use coding from the latest control write
// - full scale maps onto 8192 codes at whole lsb steps
// - reset gives eight single-ended inputs until control is written
// - tracking starts on 14th serial clock rise after select falls
// - hold resumes when select falls for the next frame
// - differential span maps onto codes -4096 to +4095
// - differential mode pairs eight inputs into four pairs
// - every channel keeps its own one-of-four range
// - each transfer spans exactly sixteen serial clocks
// - serial clock shifts results and steps the conversion
// - two mode bits of the control word pick input configuration
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl #(
	parameter int chans = 8
) (
	input  wire logic                 sys_clk_in,
	input  wire logic                 sys_rst_in,
	input  wire logic                 sclk_in,
	input  wire logic                 cs_n_in,
	input  wire logic                 din_in,
	input  wire logic [12:0]          held_code_in,
	output logic                      dout_out,
	output logic                      dout_oe_out,
	output logic                      track_out,
	output logic                      conv_step_out,
	output logic                      acq_ok_out,
	output logic [2:0]                pos_sel_out,
	output logic [2:0]                neg_sel_out,
	output adc_ctrl_pkg::neg_src_type neg_src_out,
	output logic [1:0]                range_out,
	output logic [1:0]                mode_out,
	output logic                      coding_out,
	output logic [1:0]                power_out,
	output logic                      int_ref_out,
	output logic                      weak_out
);
	// three-bit selects and the eight-bit mask serve eight channels only
	if (chans != adc_ctrl_pkg::chan_n) begin : g_chans
		$error("channel count must be eight");
	end

	link_evt_if evt ();

	link_sync sync_u (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.sclk_in    (sclk_in),
		.cs_n_in    (cs_n_in),
		.din_in     (din_in),
		.evt        (evt)
	);

	logic [11:0] ctrl_q;
	logic [15:0] range_q;
	logic [7:0]  seq_q;
	logic [2:0]  chan_q;
	logic [2:0]  conv_chan_q;
	logic [4:0]  rise_cnt_q;
	logic [4:0]  fall_cnt_q;
	logic [15:0] rx_q;
	logic [15:0] tx_q;
	logic        wrote_q;
	logic        track_q;
	logic [7:0]  acq_cnt_q;
	logic        acq_ok_q;
	logic        step_q;
	logic [15:0] rx_d;
	logic        word_done;
	logic [1:0]  seq_mode;

	// control word bit k is kept at ctrl_q[k - 1]
	assign seq_mode = ctrl_q[adc_ctrl_pkg::seq_hi - 1:adc_ctrl_pkg::seq_lo - 1];

	// next enabled channel after cur in the sequence mask, wrapping
	function automatic logic [2:0] next_seq(input logic [2:0] cur,
		input logic [7:0] mask);
		logic [2:0] n;
		logic [2:0] pick;
		logic       found;
		pick  = cur;
		found = 1'b0;
		for (int i = 1; i <= 8; i++) begin
			n = cur + i[2:0];
			if (!found && mask[n]) begin
				pick  = n;
				found = 1'b1;
			end
		end
		return pick;
	endfunction

	function automatic logic [1:0] chan_range(input logic [2:0] ch,
		input logic [15:0] rng);
		return rng[5'(15 - 2 * int'(ch)) -: 2];
	endfunction

	// incoming word is complete only on the sixteenth falling edge
	assign rx_d      = {rx_q[14:0], evt.din};
	assign word_done = evt.sclk_fall &&
		(fall_cnt_q == adc_ctrl_pkg::frame_edges - 5'h01);

	// edge counters per frame
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in || evt.sel_fall) begin
			rise_cnt_q <= 5'h00;
			fall_cnt_q <= 5'h00;
		end else if (evt.sel_act) begin
			if (evt.sclk_rise && rise_cnt_q != 5'h1f)
				rise_cnt_q <= rise_cnt_q + 5'h01;
			if (evt.sclk_fall && fall_cnt_q != 5'h1f)
				fall_cnt_q <= fall_cnt_q + 5'h01;
		end
	end

	// serial input is sampled on falling serial clock edges
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			rx_q <= 16'h0000;
		else if (evt.sclk_fall)
			rx_q <= rx_d;
	end

	// every control field is zero after reset
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ctrl_q  <= adc_ctrl_pkg::ctrl_rst;
			range_q <= adc_ctrl_pkg::range_rst;
			seq_q   <= adc_ctrl_pkg::seq_rst;
		end else if (word_done && rx_d[adc_ctrl_pkg::wr_bit]) begin
			if (rx_d[14:13] == adc_ctrl_pkg::sel_ctrl)
				ctrl_q <= rx_d[12:1];
			else if (rx_d[14:13] == adc_ctrl_pkg::sel_range1)
				range_q[15:8] <= rx_d[12:5];
			else if (rx_d[14:13] == adc_ctrl_pkg::sel_range2)
				range_q[7:0] <= rx_d[12:5];
			else
				seq_q <= rx_d[12:5];
		end
	end

	// channel for the next conversion; sequencer steps at frame end
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			chan_q  <= 3'h0;
			wrote_q <= 1'b0;
		end else if (word_done && rx_d[adc_ctrl_pkg::wr_bit] &&
			rx_d[14:13] == adc_ctrl_pkg::sel_ctrl) begin
			chan_q  <= rx_d[adc_ctrl_pkg::add_hi:adc_ctrl_pkg::add_lo];
			wrote_q <= 1'b1;
		end else if (evt.sel_rise) begin
			if (!wrote_q && seq_mode != 2'h0 && seq_q != 8'h00)
				chan_q <= next_seq(chan_q, seq_q);
			wrote_q <= 1'b0;
		end
	end

	// hold on select fall; track on the fourteenth rise
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			track_q <= 1'b1;
		else if (evt.sel_fall)
			track_q <= 1'b0;
		else if (evt.sclk_rise &&
			rise_cnt_q == adc_ctrl_pkg::track_edge - 5'h01)
			track_q <= 1'b1;
	end

	// flags a hold that came after enough settling time
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			acq_cnt_q <= 8'h00;
			acq_ok_q  <= 1'b0;
		end else if (evt.sel_fall) begin
			acq_ok_q  <= acq_cnt_q >= 8'(adc_ctrl_pkg::acq_min_cyc);
			acq_cnt_q <= 8'h00;
		end else if (track_q && acq_cnt_q != 8'hff) begin
			acq_cnt_q <= acq_cnt_q + 8'h01;
		end
	end

	// conversion steps on serial clock rises while holding
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in)
			step_q <= 1'b0;
		else
			step_q <= evt.sclk_rise && !track_q;
	end

	// result word: channel then 13-bit code
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			tx_q        <= 16'h0000;
			conv_chan_q <= 3'h0;
		end else if (evt.sel_fall) begin
			conv_chan_q <= chan_q;
			// coding bit from the latest control write
			tx_q <= {chan_q,
				held_code_in[12] ^ ctrl_q[adc_ctrl_pkg::coding_bit - 1],
				held_code_in[11:0]};
		end else if (evt.sclk_fall) begin
			// results shift out on serial clock falls
			tx_q <= {tx_q[14:0], 1'b0};
		end
	end

	// pairs and common negative input by configuration
	always_comb begin
		pos_sel_out = conv_chan_q;
		neg_sel_out = 3'h0;
		neg_src_out = adc_ctrl_pkg::neg_ground;
		if (ctrl_q[8:7] == adc_ctrl_pkg::mode_diff ||
			ctrl_q[8:7] == adc_ctrl_pkg::mode_pseudo4) begin
			pos_sel_out = {conv_chan_q[2:1], 1'b0};
			neg_sel_out = {conv_chan_q[2:1], 1'b1};
			neg_src_out = adc_ctrl_pkg::neg_pair;
		end else if (ctrl_q[8:7] == adc_ctrl_pkg::mode_pseudo7) begin
			neg_sel_out = 3'h7;
			neg_src_out = adc_ctrl_pkg::neg_common;
		end
	end

	assign dout_out      = tx_q[15];
	assign dout_oe_out   = evt.sel_act;
	assign track_out     = track_q;
	assign conv_step_out = step_q;
	assign acq_ok_out    = acq_ok_q;
	assign range_out     = chan_range(conv_chan_q, range_q);
	assign mode_out      = ctrl_q[8:7];
	assign coding_out    = ctrl_q[adc_ctrl_pkg::coding_bit - 1];
	assign power_out     = ctrl_q[6:5];
	assign int_ref_out   = ctrl_q[adc_ctrl_pkg::ref_bit - 1];
	assign weak_out      = ctrl_q[adc_ctrl_pkg::wts_bit - 1];
endmodule
`default_nettype wire

// ---- rtl/adc_ctrl_pkg.sv ----
// shared constants and types for the converter control block
package adc_ctrl_pkg;
	localparam int word_w       = 16;
	localparam int code_w       = 13;
	localparam int chan_n       = 8;
	// serial word layout, msb first
	localparam int wr_bit       = 15;
	localparam int sel_hi       = 14;
	localparam int sel_lo       = 13;
	localparam int add_hi       = 12;
	localparam int add_lo       = 10;
	localparam int mode_hi      = 9;
	localparam int mode_lo      = 8;
	localparam int pm_hi        = 7;
	localparam int pm_lo        = 6;
	localparam int coding_bit   = 5;
	localparam int ref_bit      = 4;
	localparam int seq_hi       = 3;
	localparam int seq_lo       = 2;
	localparam int wts_bit      = 1;
	localparam int data8_hi     = 12;
	localparam int data8_lo     = 5;
	// register selects
	localparam logic [1:0] sel_ctrl   = 2'h0;
	localparam logic [1:0] sel_range1 = 2'h1;
	localparam logic [1:0] sel_range2 = 2'h2;
	localparam logic [1:0] sel_seq    = 2'h3;
	// input configuration codes
	localparam logic [1:0] mode_single  = 2'h0;
	localparam logic [1:0] mode_diff    = 2'h1;
	localparam logic [1:0] mode_pseudo4 = 2'h2;
	localparam logic [1:0] mode_pseudo7 = 2'h3;
	// reset values
	localparam logic [11:0] ctrl_rst  = 12'h000;
	localparam logic [15:0] range_rst = 16'h0000;
	localparam logic [7:0]  seq_rst   = 8'h00;
	// frame timing in serial clock edges
	localparam logic [4:0] frame_edges = 5'h10;
	localparam logic [4:0] track_edge  = 5'h0e;
	// least settling time before the next hold
	localparam int sys_clk_mhz  = 50;
	localparam int acq_min_ns   = 305;
	localparam int acq_min_cyc  = (acq_min_ns * sys_clk_mhz + 999) / 1000;
	typedef enum logic [1:0] {neg_ground, neg_pair, neg_common} neg_src_type;
endpackage

// ---- rtl/link_evt_if.sv ----
// edge events of the serial link, in the system clock domain
`timescale 1ns/10ps
`default_nettype none
interface link_evt_if;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_fall;
	logic sel_rise;
	logic sel_act;
	logic din;
	modport src (output sclk_rise, sclk_fall, sel_fall, sel_rise, sel_act,
		din);
	modport dst (input sclk_rise, sclk_fall, sel_fall, sel_rise, sel_act,
		din);
endinterface
`default_nettype wire

// ---- rtl/link_sync.sv ----
// synchronises the serial pins and finds their edges
`timescale 1ns/10ps
`default_nettype none
module link_sync (
	input  wire logic sys_clk_in,
	input  wire logic sys_rst_in,
	input  wire logic sclk_in,
	input  wire logic cs_n_in,
	input  wire logic din_in,
	link_evt_if.src   evt
);
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic       sclk_old_q;
	logic       cs_n_old_q;

	// first stage read only by the second
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			meta_q <= 3'h3;
			sync_q <= 3'h3;
		end else begin
			meta_q <= {din_in, cs_n_in, sclk_in};
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			sclk_old_q <= 1'b1;
			cs_n_old_q <= 1'b1;
		end else begin
			sclk_old_q <= sync_q[0];
			cs_n_old_q <= sync_q[1];
		end
	end

	assign evt.sclk_rise = sync_q[0] & ~sclk_old_q & ~sync_q[1];
	assign evt.sclk_fall = ~sync_q[0] & sclk_old_q & ~sync_q[1];
	assign evt.sel_fall  = ~sync_q[1] & cs_n_old_q;
	assign evt.sel_rise  = sync_q[1] & ~cs_n_old_q;
	assign evt.sel_act   = ~sync_q[1];
	assign evt.din       = sync_q[2];
endmodule
`default_nettype wire

// ---- test/adc_ctrl_asserts.sv ----
// port checks for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_asserts (
	input wire logic       sys_clk_in,
	input wire logic       sys_rst_in,
	input wire logic       track_out,
	input wire logic       conv_step_out,
	input wire logic       dout_oe_out,
	input wire logic       coding_out,
	input wire logic [1:0] mode_out,
	input wire logic [2:0] pos_sel_out,
	input wire logic [2:0] neg_sel_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	property p_rst_code; $fell(sys_rst_in) |-> !coding_out; endproperty
	a_rst_code: assert property (p_rst_code) else $error("coding");
	property p_rst_mode; $fell(sys_rst_in) |-> mode_out == 2'h0; endproperty
	a_rst_mode: assert property (p_rst_mode) else $error("mode");
	property p_trk; $rose(track_out) |-> dout_oe_out; endproperty
	a_trk: assert property (p_trk) else $error("track start");
	property p_hold; $fell(track_out) |-> dout_oe_out; endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_hold_sel; $rose(dout_oe_out) |=> !track_out; endproperty
	a_hold_sel: assert property (p_hold_sel) else $error("hold start");
	// a step launched while tracking would convert an unsettled sample
	property p_step; conv_step_out |-> !$past(track_out); endproperty
	a_step: assert property (p_step) else $error("step");
	property p_pulse; conv_step_out |=> !conv_step_out; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_pair;
		mode_out == adc_ctrl_pkg::mode_diff |->
			!pos_sel_out[0] && neg_sel_out == pos_sel_out + 3'h1;
	endproperty
	a_pair: assert property (p_pair) else $error("pair");
	property p_p7;
		mode_out == adc_ctrl_pkg::mode_pseudo7 |-> neg_sel_out == 3'h7;
	endproperty
	a_p7: assert property (p_p7) else $error("common");
	c_trk: cover property ($rose(track_out));
	c_bin: cover property ($rose(coding_out));
	c_diff: cover property (mode_out == adc_ctrl_pkg::mode_diff);
endmodule
bind adc_ctrl adc_ctrl_asserts u_chk (.sys_clk_in, .sys_rst_in,
	.track_out, .conv_step_out, .dout_oe_out, .coding_out, .mode_out,
	.pos_sel_out, .neg_sel_out);
`default_nettype wire

// ---- test/host_link.sv ----
// host side of the serial link: clock, select and data
`timescale 1ns/10ps
`default_nettype none
module host_link (
	input  wire logic sys_clk_in,
	input  wire logic dout_in,
	output var logic  sclk_out,
	output var logic  cs_n_out,
	output var logic  din_out
);
	initial begin
		sclk_out = 1'b1;
		cs_n_out = 1'b1;
		din_out = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic frame(input logic [15:0] w, output logic [15:0] rx);
		cs_n_out <= 1'b0;
		wait_n(8);
		for (int i = 15; i >= 0; i--) begin
			din_out <= w[i];
			wait_n(4);
			rx[i] = dout_in;
			sclk_out <= 1'b0;
			wait_n(4);
			sclk_out <= 1'b1;
		end
		wait_n(4);
		cs_n_out <= 1'b1;
		// released line shows the inverse, not a stale bit
		din_out <= ~w[0];
		// quiet gap keeps tracking past 305 ns
		wait_n(24);
	endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        sys_clk_in, sys_rst_in, sclk_in, cs_n_in, din_in;
	logic        dout_out, dout_oe_out, track_out, conv_step_out;
	logic        acq_ok_out, coding_out, int_ref_out, weak_out;
	logic [12:0] held_code_in;
	logic [2:0]  pos_sel_out, neg_sel_out;
	logic [1:0]  range_out, mode_out, power_out;
	logic [15:0] cfg, rr;
	logic [31:0] st;
	int          n_errors, checks_done;
	adc_ctrl_pkg::neg_src_type neg_src_out;
	adc_ctrl u_dut (.sys_clk_in, .sys_rst_in, .sclk_in, .cs_n_in, .din_in,
		.held_code_in, .dout_out, .dout_oe_out, .track_out, .conv_step_out,
		.acq_ok_out, .pos_sel_out, .neg_sel_out, .neg_src_out, .range_out,
		.mode_out, .coding_out, .power_out, .int_ref_out, .weak_out);
	host_link u_host (.sys_clk_in, .dout_in(dout_out), .sclk_out(sclk_in),
		.cs_n_out(cs_n_in), .din_out(din_in));
	assign cfg = {6'h00, mode_out, power_out, coding_out, int_ref_out,
		2'h0, weak_out, 1'b0};
	logic [15:0] sel_seen;
	assign sel_seen = {8'h00, 2'(neg_src_out), pos_sel_out, neg_sel_out};
	function automatic logic [31:0] rnd();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction
	function automatic logic [15:0] exp_word(input logic [2:0] ch,
		input logic [12:0] c, input logic cd);
		return {ch, c[12] ^ cd, c[11:0]};
	endfunction
	// sequencer moves on to the next enabled channel, wrapping
	function automatic logic [2:0] nxt(input logic [2:0] c,
		input logic [7:0] m);
		logic [2:0] n;
		n = c + 3'h1;
		while (!m[n])
			n = n + 3'h1;
		return n;
	endfunction
	// input routing expected for each configuration
	function automatic logic [15:0] exp_sel(input logic [1:0] md,
		input logic [2:0] ch);
		if (md == adc_ctrl_pkg::mode_diff ||
			md == adc_ctrl_pkg::mode_pseudo4)
			return {8'h00, 2'(adc_ctrl_pkg::neg_pair), ch[2:1], 1'b0,
				ch[2:1], 1'b1};
		if (md == adc_ctrl_pkg::mode_pseudo7)
			return {8'h00, 2'(adc_ctrl_pkg::neg_common), ch, 3'h7};
		return {8'h00, 2'(adc_ctrl_pkg::neg_ground), ch, 3'h0};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// result bits outside mask m are ignored; every call here checks the whole word
	task automatic xfer(input logic [15:0] w, input logic [2:0] ch,
		input logic cd, input logic [15:0] m);
		logic [31:0] r;
		logic [15:0] rx;
		r = rnd();
		held_code_in <= r[12:0];
		@(posedge sys_clk_in);
		u_host.frame(w, rx);
		chk("result", exp_word(ch, r[12:0], cd) & m, rx & m);
		chk("track", 16'h0001, {15'h0000, track_out});
	endtask
	initial begin
		sys_clk_in = 1'b0;
		forever #10 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		n_errors++;
		complete_run();
	end
	initial begin
		logic [31:0] r;
		logic [15:0] w;
		logic [2:0]  pch;
		logic        pcd;
		logic [7:0]  sm;
		sys_rst_in = 1'b1;
		held_code_in = 13'h0000;
		st = 32'h00001ca7;
		pch = 3'h0;
		pcd = 1'b0;
		repeat (10) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		chk("config", 16'h0000, cfg);
		r = rnd();
		rr = r[31:16];
		xfer({1'b0, r[14:0]}, 3'h0, 1'b0, 16'hffff);
		xfer({3'h5, rr[15:8], 5'h00}, 3'h0, 1'b0, 16'hffff);
		xfer({3'h6, rr[7:0], 5'h00}, 3'h0, 1'b0, 16'hffff);
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			w = {3'h4, i[2:0], (i < 8) ? 2'h0 : i[1:0], r[7:4], 2'h0,
				r[1], 1'b0};
			xfer(w, pch, pcd, 16'hffff);
			chk("config", w & 16'h03f2, cfg);
			pch = i[2:0];
			pcd = w[5];
			xfer({1'b0, r[30:16]}, pch, pcd, 16'hffff);
			chk("inputs", exp_sel(w[9:8], pch), sel_seen);
			if (i < 8) begin
				chk("range", {14'h0, rr[15 - 2 * i -: 2]}, {14'h0, range_out});
			end
		end
		r = rnd();
		sm = {r[7:1], 1'b1};
		xfer({3'h7, sm, 5'h00}, pch, pcd, 16'hffff);
		xfer(16'h8024, pch, pcd, 16'hffff);
		// the control write picks channel 0, then the mask takes over
		pch = 3'h0;
		for (int k = 0; k < 4; k++) begin
			xfer({1'b0, st[14:0]}, pch, 1'b1, 16'hffff);
			pch = nxt(pch, sm);
		end
		chk("config", 16'h0020, cfg);
		chk("acquire", 16'h0001, {15'h0000, acq_ok_out});
		complete_run();
	end
endmodule
`default_nettype wire
